// [shared/bfx_cfg.svh]
// Purpose: offsets, field positions, reset values and encodings of the branch/bit-clear executor
// Assumes: included by bare name from every design file that needs it
// Notes:   definitions only
`ifndef BFX_CFG_SVH
`define BFX_CFG_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define BFX_REG_CTRL    8'h00
`define BFX_REG_BANK    8'h04
`define BFX_REG_FLAGS   8'h08
`define BFX_REG_PC      8'h0C
`define BFX_REG_STAT    8'h10

// ****************************************
// field positions and reset values
// ****************************************
`define BFX_CTRL_RUN    0
`define BFX_FLAG_C      0
`define BFX_FLAG_N      1
`define BFX_STAT_TAKEN  0
`define BFX_STAT_UNSUP  1
`define BFX_STAT_BUSY   2
`define BFX_BANK_RST    4'h0
`define BFX_FLAGS_RST   2'h0
`define BFX_ACCESS_BANK 4'h0
`define BFX_PC_W_DEF    21

// ****************************************
// instruction encodings
// ****************************************
`define BFX_NOP_WORD    16'h0000
`define BFX_PFX_BCLR    4'h9
`define BFX_OPC_BNEG    8'hE6
`define BFX_OPC_BNC     8'hE3

// ****************************************
// phases of one instruction cycle
// ****************************************
`define BFX_Q1          2'h0
`define BFX_Q2          2'h1
`define BFX_Q3          2'h2
`define BFX_Q4          2'h3

`endif

// [shared/bfx_pkg.sv]
// Purpose: types shared by the branch/bit-clear executor
// Assumes: nothing
// Notes:   constants live in bfx_cfg.svh
package bfx_pkg;

    typedef enum logic [2:0] {
        BFX_OP_NOP,
        BFX_OP_BCLR,
        BFX_OP_BNEG,
        BFX_OP_BNC,
        BFX_OP_OTHER
    } bfx_op_e;

    typedef struct packed {
        bfx_op_e    op;
        logic [2:0] bit_idx;
        logic       bank_sel;
        logic [7:0] faddr;
        logic [7:0] offset;
    } bfx_dec_s;

    typedef struct packed {
        logic       rd;
        logic       we;
        logic [11:0] addr;
        logic [7:0] wdata;
    } bfx_dmem_req_s;

endpackage

// [design/bfx_decode.sv]
// Purpose: splits an instruction word into operation and operand fields
// Assumes: word is stable for the whole instruction cycle
// Notes:   purely combinational
`timescale 1ns/1ps
`include "bfx_cfg.svh"
module bfx_decode
    import bfx_pkg::*;
(
    input  wire logic [15:0] word_i,
    output bfx_dec_s         dec_o
);

    // ****************************************
    // operation decode
    // ****************************************
    wire is_nop  = (word_i == `BFX_NOP_WORD);
    wire is_bclr = (word_i[15:12] == `BFX_PFX_BCLR);
    wire is_bneg = (word_i[15:8] == `BFX_OPC_BNEG);
    wire is_bnc  = (word_i[15:8] == `BFX_OPC_BNC);

    bfx_op_e op_sel;

    assign op_sel = is_nop  ? BFX_OP_NOP  :
                    is_bclr ? BFX_OP_BCLR :
                    is_bneg ? BFX_OP_BNEG :
                    is_bnc  ? BFX_OP_BNC  : BFX_OP_OTHER;

    // bit index, bank select and register address share the low twelve bits
    assign dec_o = '{op:       op_sel,
                     bit_idx:  word_i[11:9],
                     bank_sel: word_i[8],
                     faddr:    word_i[7:0],
                     offset:   word_i[7:0]};

endmodule

// [design/bfx_qphase.sv]
// Purpose: four-phase sequencer of one instruction cycle
// Assumes: run_i comes from logic on the same clock
// Notes:   a started cycle always runs to its fourth phase
`timescale 1ns/1ps
`include "bfx_cfg.svh"
module bfx_qphase
    import bfx_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       run_i,
    output logic      [1:0] q_o,
    output logic            active_o
);

    logic [1:0] q_reg;

    // ****************************************
    // phase counter
    // ****************************************
    assign active_o = run_i || (q_reg != `BFX_Q1);
    assign q_o      = q_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_reg <= `BFX_Q1;
        end else if (active_o) begin
            q_reg <= q_reg + 2'h1;
        end
    end

    AST_QPH_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        (!active_o) |=> (q_reg == `BFX_Q1))
        else $error("phase left Q1 while idle");

endmodule

// [design/bfx_exec.sv]
// Purpose: executes bit clear and two conditional relative branches
// Assumes: instruction and data memories answer within the phase that asks
// Notes:   one instruction cycle is four clocks, Q1 to Q4
// Function
// - word with upper byte E6 branches only when the negative flag is one.
// - branch_on_carry_clear branches only when carry is zero, else goes on in sequence.
// - upper byte E3 selects branch_on_carry_clear, low byte being the offset.
// - a taken branch loads the counter with the incremented address plus twice the offset.
// - the offset byte is two's complement from -128 to 127.
// - a branch is one word, one cycle when not taken and two cycles when taken.
// - decode in Q1, read offset in Q2, process in Q3, write the counter in Q4 if taken.
// - the branches never alter any status flag.
// - bit_clear_in_register zeroes one bit of the register and leaves the rest alone.
// - bit clear is prefix 1001, three-bit index, bank select bit and eight-bit address.
// - bank select zero uses the access bank, one uses bank_pointer_register.
`timescale 1ns/1ps
`include "bfx_cfg.svh"
module bfx_exec
    import bfx_pkg::*;
#(
    parameter int PC_W = `BFX_PC_W_DEF
)(
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic [7:0]      wb_adr_i,
    input  wire logic [31:0]     wb_dat_i,
    output logic      [31:0]     wb_dat_o,
    input  wire logic            wb_we_i,
    input  wire logic [3:0]      wb_sel_i,
    input  wire logic            wb_cyc_i,
    input  wire logic            wb_stb_i,
    output logic                 wb_ack_o,
    output logic      [PC_W-1:0] fetch_addr_o,
    input  wire logic [15:0]     instr_i,
    output bfx_dmem_req_s        dmem_req_o,
    input  wire logic [7:0]      dmem_rdata_i
);

    // ****************************************
    // elaboration check
    // ****************************************
    if (PC_W < 9 || PC_W > 32) begin : g_chk
        $error("PC_W must lie between 9 and 32");
    end

    // ****************************************
    // functions
    // ****************************************
    function automatic logic [PC_W-1:0] branch_target(
        input logic [PC_W-1:0] base,
        input logic [7:0]      n
    );
        branch_target = base + {{(PC_W-9){n[7]}}, n, 1'b0};
    endfunction

    function automatic logic [31:0] lane_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  sel
    );
        for (int i = 0; i < 4; i++) begin
            lane_merge[8*i +: 8] = sel[i] ? new_v[8*i +: 8] : old_v[8*i +: 8];
        end
    endfunction

    // ****************************************
    // state
    // ****************************************
    logic            run_reg;
    logic [3:0]      bank_reg;
    logic [1:0]      flags_reg;
    logic [PC_W-1:0] pc_reg;
    logic [PC_W-1:0] fetch_addr_reg;
    logic [15:0]     ir_reg;
    logic [7:0]      offset_reg;
    logic [7:0]      rdata_reg;
    logic            taken_reg;
    logic [PC_W-1:0] target_reg;
    logic            last_taken_reg;
    logic            unsup_reg;
    logic            ack_reg;
    logic [31:0]     dat_reg;
    bfx_dmem_req_s   dmem_reg;

    logic [1:0]      q;
    logic            active;
    bfx_dec_s        dec;

    // ****************************************
    // sequencer and decoder
    // ****************************************
    bfx_qphase u_qphase (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .run_i    (run_reg),
        .q_o      (q),
        .active_o (active)
    );

    bfx_decode u_decode (
        .word_i (ir_reg),
        .dec_o  (dec)
    );

    // ****************************************
    // phase and operation decode
    // ****************************************
    wire at_q1     = active && (q == `BFX_Q1);
    wire at_q2     = active && (q == `BFX_Q2);
    wire at_q3     = active && (q == `BFX_Q3);
    wire at_q4     = active && (q == `BFX_Q4);
    wire op_bclr   = (dec.op == BFX_OP_BCLR);
    wire op_branch = (dec.op == BFX_OP_BNEG) || (dec.op == BFX_OP_BNC);

    wire cond_neg  = (dec.op == BFX_OP_BNEG) && flags_reg[`BFX_FLAG_N];
    wire cond_nc   = (dec.op == BFX_OP_BNC) && !flags_reg[`BFX_FLAG_C];
    wire cond_hit  = cond_neg || cond_nc;

    // access bank unless the instruction asks for the pointed bank
    wire [3:0]  dm_bank  = dec.bank_sel ? bank_reg : `BFX_ACCESS_BANK;
    wire [11:0] dm_addr  = {dm_bank, dec.faddr};
    wire [7:0]  clr_data = rdata_reg & ~(8'h01 << dec.bit_idx);

    // ****************************************
    // bus decode
    // ****************************************
    wire bus_req  = wb_cyc_i && wb_stb_i && !ack_reg;
    wire bus_wr   = bus_req && wb_we_i;
    wire wr_ctrl  = bus_wr && (wb_adr_i == `BFX_REG_CTRL) && wb_sel_i[0];
    wire wr_bank  = bus_wr && (wb_adr_i == `BFX_REG_BANK) && wb_sel_i[0];
    wire wr_flags = bus_wr && (wb_adr_i == `BFX_REG_FLAGS) && wb_sel_i[0];
    wire wr_stat  = bus_wr && (wb_adr_i == `BFX_REG_STAT) && wb_sel_i[0];
    // counter is loaded by software only while the sequencer is idle
    wire wr_pc    = bus_wr && (wb_adr_i == `BFX_REG_PC) && !active;

    wire [31:0] pc_word   = {{(32-PC_W){1'b0}}, pc_reg};
    wire [31:0] pc_merged = lane_merge(pc_word, wb_dat_i, wb_sel_i);
    wire [31:0] stat_word = {29'h0, active, unsup_reg, last_taken_reg};

    wire [31:0] rd_mux =
        (wb_adr_i == `BFX_REG_CTRL)  ? {31'h0, run_reg}   :
        (wb_adr_i == `BFX_REG_BANK)  ? {28'h0, bank_reg}  :
        (wb_adr_i == `BFX_REG_FLAGS) ? {30'h0, flags_reg} :
        (wb_adr_i == `BFX_REG_PC)    ? pc_word            :
        (wb_adr_i == `BFX_REG_STAT)  ? stat_word          : 32'h0;

    wire unsup_set = at_q1 && (dec.op == BFX_OP_OTHER);
    wire unsup_clr = wr_stat && wb_dat_i[`BFX_STAT_UNSUP];

    // ****************************************
    // wishbone slave
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_reg <= 32'h0;
        end else if (bus_req && !wb_we_i) begin
            dat_reg <= rd_mux;
        end
    end

    // ****************************************
    // software registers
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_reg  <= 1'b0;
            bank_reg <= `BFX_BANK_RST;
        end else begin
            if (wr_ctrl) begin
                run_reg <= wb_dat_i[`BFX_CTRL_RUN];
            end
            if (wr_bank) begin
                bank_reg <= wb_dat_i[3:0];
            end
        end
    end

    // status flags change only by software, never by execution
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_reg <= `BFX_FLAGS_RST;
        end else if (wr_flags) begin
            flags_reg <= wb_dat_i[1:0];
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            unsup_reg <= 1'b0;
        end else if (unsup_set) begin
            unsup_reg <= 1'b1;
        end else if (unsup_clr) begin
            unsup_reg <= 1'b0;
        end
    end

    // ****************************************
    // program counter and fetch
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_reg <= '0;
        end else if (at_q1) begin
            pc_reg <= pc_reg + PC_W'(2);
        end else if (at_q4 && taken_reg) begin
            pc_reg <= target_reg;
        end else if (wr_pc) begin
            pc_reg <= {pc_merged[PC_W-1:1], 1'b0};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fetch_addr_reg <= '0;
        end else if (at_q1) begin
            fetch_addr_reg <= pc_reg;
        end
    end

    // prefetched word is dropped on a taken branch or a new counter value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ir_reg <= `BFX_NOP_WORD;
        end else if (wr_pc) begin
            ir_reg <= `BFX_NOP_WORD;
        end else if (at_q4) begin
            ir_reg <= taken_reg ? `BFX_NOP_WORD : instr_i;
        end
    end

    // ****************************************
    // branch evaluation
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            offset_reg <= 8'h00;
        end else if (at_q2 && op_branch) begin
            offset_reg <= dec.offset;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            taken_reg  <= 1'b0;
            target_reg <= '0;
        end else if (at_q3) begin
            taken_reg  <= cond_hit;
            // counter is a word ahead here; the base is the word after the branch
            target_reg <= branch_target(fetch_addr_reg, offset_reg);
        end else if (at_q1) begin
            taken_reg  <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_taken_reg <= 1'b0;
        end else if (at_q4 && op_branch) begin
            last_taken_reg <= taken_reg;
        end
    end

    // ****************************************
    // bit clear read-modify-write
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_reg <= 8'h00;
        end else if (at_q2 && op_bclr) begin
            rdata_reg <= dmem_rdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dmem_reg <= '0;
        end else begin
            dmem_reg.rd <= at_q1 && op_bclr;
            dmem_reg.we <= at_q3 && op_bclr;
            if (at_q1 && op_bclr) begin
                dmem_reg.addr <= dm_addr;
            end
            if (at_q3 && op_bclr) begin
                dmem_reg.wdata <= clr_data;
            end
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign wb_ack_o     = ack_reg;
    assign wb_dat_o     = dat_reg;
    assign fetch_addr_o = fetch_addr_reg;
    assign dmem_req_o   = dmem_reg;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_BNEG_COND: assert property (
        (at_q3 && dec.op == BFX_OP_BNEG) |=> (taken_reg == $past(flags_reg[`BFX_FLAG_N])))
        else $error("negative branch decision wrong");

    AST_BNC_COND: assert property (
        (at_q3 && dec.op == BFX_OP_BNC) |=> (taken_reg == !$past(flags_reg[`BFX_FLAG_C])))
        else $error("carry clear branch decision wrong");

    AST_BNC_CODE: assert property (
        (at_q3 && ir_reg[15:8] == `BFX_OPC_BNC && !flags_reg[`BFX_FLAG_C]) |=> taken_reg)
        else $error("carry clear code not taken");

    AST_TARGET: assert property (
        (at_q4 && taken_reg) |=> (pc_reg ==
            branch_target($past(fetch_addr_reg), $past(ir_reg[7:0]))))
        else $error("branch target wrong");

    AST_NOT_TAKEN: assert property (
        (at_q4 && op_branch && !taken_reg)
            |=> (pc_reg == $past(pc_reg)) && (ir_reg == $past(instr_i)))
        else $error("untaken branch disturbed sequence");

    AST_FLUSH: assert property (
        (at_q4 && taken_reg) |=> (ir_reg == `BFX_NOP_WORD) ##4 (taken_reg == 1'b0))
        else $error("prefetch not dropped after taken branch");

    AST_PC_PHASE: assert property (
        ($past(active) && pc_reg != $past(pc_reg))
            |-> ($past(q) == `BFX_Q1 || ($past(q) == `BFX_Q4 && $past(taken_reg))))
        else $error("counter moved outside Q1 or Q4");

    AST_FLAGS_KEPT: assert property (
        (!wr_flags) |=> (flags_reg == $past(flags_reg)))
        else $error("flags changed by execution");

    AST_BCLR_WR: assert property (
        (at_q3 && op_bclr) |=> dmem_req_o.we
            && (dmem_req_o.wdata == ($past(rdata_reg) & ~(8'h01 << $past(dec.bit_idx)))))
        else $error("bit clear write data wrong");

    AST_BCLR_ADDR: assert property (
        (at_q1 && op_bclr) |=> dmem_req_o.rd && (dmem_req_o.addr ==
            {($past(dec.bank_sel) ? $past(bank_reg) : `BFX_ACCESS_BANK), $past(dec.faddr)}))
        else $error("bit clear address wrong");

    COV_BNEG_TAKEN: cover property (at_q4 && taken_reg && dec.op == BFX_OP_BNEG);
    COV_BNC_TAKEN: cover property (at_q4 && taken_reg && dec.op == BFX_OP_BNC);
    COV_BNC_SKIP: cover property (at_q4 && !taken_reg && dec.op == BFX_OP_BNC);
    COV_BCLR_WRITE: cover property (dmem_req_o.we);

endmodule

// [dv/bfx_mem_model.sv]
// Purpose: program memory and data memory facing the executor
// Assumes: both memories answer combinationally within the asking phase
// Notes:   the bench loads prog and data directly while the sequencer is stopped
`timescale 1ns/1ps
module bfx_mem_model
    import bfx_pkg::*;
#(
    parameter int PC_W = 21
)(
    input  wire logic            clk_i,
    input  wire logic [PC_W-1:0] fetch_addr_i,
    output logic      [15:0]     instr_o,
    input  wire bfx_dmem_req_s   dmem_req_i,
    output logic      [7:0]      dmem_rdata_o
);
    logic [15:0] prog [2048];
    logic [7:0]  data [4096];
    int          wr_count;

    initial begin
        for (int i = 0; i < 4096; i++) begin
            data[i] = 8'h00;
            if (i < 2048) begin
                prog[i] = 16'h0000;
            end
        end
        wr_count = 0;
    end

    assign instr_o = prog[fetch_addr_i[11:1]];
    // outside a read the data lines carry inverted junk, never the last value
    assign dmem_rdata_o = dmem_req_i.rd ? data[dmem_req_i.addr] : ~data[dmem_req_i.addr];

    always @(posedge clk_i) begin
        if (dmem_req_i.we === 1'b1) begin
            data[dmem_req_i.addr] <= dmem_req_i.wdata;
            wr_count <= wr_count + 1;
        end
    end
endmodule

// [dv/testbench.sv]
// Purpose: self-checking bench of the branch and bit clear executor
// Assumes: registers reached over classic Wishbone, memories from bfx_mem_model
// Notes:   after the reset check, each scenario loads a short program, runs it, stops and inspects
`timescale 1ns/1ps
`include "bfx_cfg.svh"
module testbench
    import bfx_pkg::*;
;
    localparam int PC_W = `BFX_PC_W_DEF;
    logic            clk_i;
    logic            rst_i;
    logic            wb_we_i;
    logic            wb_cyc_i;
    logic            wb_stb_i;
    logic            wb_ack_o;
    logic [7:0]      wb_adr_i;
    logic [31:0]     wb_dat_i;
    logic [31:0]     wb_dat_o;
    logic [3:0]      wb_sel_i;
    logic [PC_W-1:0] fetch_addr_o;
    logic [15:0]     instr_i;
    bfx_dmem_req_s   dmem_req_o;
    logic [7:0]      dmem_rdata_i;
    int              mismatches;
    int              num_checks;
    int              cycles;
    logic [PC_W-1:0] fetch_log [$];

    bfx_exec #(.PC_W(PC_W)) i_dut (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .wb_adr_i     (wb_adr_i),
        .wb_dat_i     (wb_dat_i),
        .wb_dat_o     (wb_dat_o),
        .wb_we_i      (wb_we_i),
        .wb_sel_i     (wb_sel_i),
        .wb_cyc_i     (wb_cyc_i),
        .wb_stb_i     (wb_stb_i),
        .wb_ack_o     (wb_ack_o),
        .fetch_addr_o (fetch_addr_o),
        .instr_i      (instr_i),
        .dmem_req_o   (dmem_req_o),
        .dmem_rdata_i (dmem_rdata_i)
    );

    bfx_mem_model #(.PC_W(PC_W)) i_mem (
        .clk_i        (clk_i),
        .fetch_addr_i (fetch_addr_o),
        .instr_o      (instr_i),
        .dmem_req_i   (dmem_req_o),
        .dmem_rdata_o (dmem_rdata_i)
    );

    // ****************************************
    // clock, timeout and fetch monitor
    // ****************************************
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            give_verdict();
        end
    end

    always @(fetch_addr_o) begin
        fetch_log.push_back(fetch_addr_o);
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wb_xfer(input logic [7:0] a, input logic we, input logic [31:0] d,
                           output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        chk({31'h0, wb_ack_o}, 32'h1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb_xfer(a, 1'b1, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        wb_xfer(a, 1'b0, 32'h0, q);
    endtask

    task automatic stop_run();
        logic [31:0] q;
        int          n;
        wr(`BFX_REG_CTRL, 32'h0);
        n = 0;
        do begin
            rd(`BFX_REG_STAT, q);
            n++;
        end while (q[`BFX_STAT_BUSY] !== 1'b0 && n < 20);
        chk({31'h0, q[`BFX_STAT_BUSY]}, 32'h0);
    endtask

    task automatic run_prog(input logic [31:0] base);
        stop_run();
        wr(`BFX_REG_PC, base);
        fetch_log.delete();
        wr(`BFX_REG_CTRL, 32'h1);
        repeat (48) @(posedge clk_i);
        stop_run();
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic test_reset();
        logic [31:0] q;
        for (int i = 0; i < 6; i++) begin
            rd(8'(i * 4), q);
            chk(q, 32'h0);
        end
        wr(8'h14, 32'hFFFFFFFF);
        rd(8'h14, q);
        chk(q, 32'h0);
        chk(32'(fetch_addr_o), 32'h0);
        chk({30'h0, dmem_req_o.rd, dmem_req_o.we}, 32'h0);
    endtask

    task automatic test_bclr();
        logic [31:0] q;
        logic [7:0]  f;
        int          w0;
        wr(`BFX_REG_BANK, 32'h5);
        wr(`BFX_REG_FLAGS, 32'h3);
        for (int i = 0; i < 8; i++) begin
            f = 8'(i * 36);
            i_mem.prog[11'h200 + 11'(i)] = {`BFX_PFX_BCLR, 3'(i), i[0], f};
            i_mem.data[{4'h5, f}] = 8'hFF;
            i_mem.data[{4'h0, f}] = 8'hFF;
        end
        w0 = i_mem.wr_count;
        run_prog(32'h400);
        for (int i = 0; i < 8; i++) begin
            f = 8'(i * 36);
            chk(32'(i_mem.data[{(i[0] ? 4'h5 : 4'h0), f}]), 32'(8'hFF & ~(8'h01 << i)));
            chk(32'(i_mem.data[{(i[0] ? 4'h0 : 4'h5), f}]), 32'hFF);
        end
        chk(32'(i_mem.wr_count - w0), 32'h8);
        rd(`BFX_REG_FLAGS, q);
        chk(q, 32'h3);
    endtask

    task automatic test_branch();
        logic [7:0]  opc [7] = '{8'hE6, 8'hE6, 8'hE6, 8'hE3, 8'hE3, 8'hE3, 8'hE2};
        logic [1:0]  flg [7] = '{2'h2, 2'h0, 2'h3, 2'h0, 2'h1, 2'h2, 2'h1};
        logic [7:0]  off [7] = '{8'h7F, 8'h80, 8'h80, 8'h80, 8'h7F, 8'h7F, 8'h40};
        logic        tk;
        logic [31:0] tgt;
        logic [31:0] q;
        for (int i = 0; i < 7; i++) begin
            tk = (opc[i] == `BFX_OPC_BNEG && flg[i][1]) || (opc[i] == `BFX_OPC_BNC && !flg[i][0]);
            tgt = 32'h602 + {{23{off[i][7]}}, off[i], 1'b0};
            i_mem.prog[11'h300] = {opc[i], off[i]};
            i_mem.prog[11'h301] = {`BFX_PFX_BCLR, 3'h0, 1'b0, 8'h80};
            i_mem.prog[tgt[11:1]] = {`BFX_PFX_BCLR, 3'h1, 1'b0, 8'h81};
            i_mem.data[12'h080] = 8'hFF;
            i_mem.data[12'h081] = 8'hFF;
            wr(`BFX_REG_FLAGS, {30'h0, flg[i]});
            run_prog(32'h600);
            chk(32'(i_mem.data[12'h080]), tk ? 32'hFF : 32'hFE);
            chk(32'(i_mem.data[12'h081]), tk ? 32'hFD : 32'hFF);
            chk(32'(fetch_log[2]), tk ? tgt : 32'h604);
            rd(`BFX_REG_FLAGS, q);
            chk(q, {30'h0, flg[i]});
            rd(`BFX_REG_STAT, q);
            chk({31'h0, q[`BFX_STAT_UNSUP]}, {31'h0, opc[i] == 8'hE2});
            if (opc[i] != 8'hE2) begin
                chk({31'h0, q[`BFX_STAT_TAKEN]}, {31'h0, tk});
            end
            i_mem.prog[tgt[11:1]] = 16'h0000;
        end
        wr(`BFX_REG_STAT, 32'h2);
        rd(`BFX_REG_STAT, q);
        chk({31'h0, q[`BFX_STAT_UNSUP]}, 32'h0);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rst_i      = 1'b1;
        wb_cyc_i   = 1'b0;
        wb_stb_i   = 1'b0;
        wb_we_i    = 1'b0;
        wb_adr_i   = 8'h00;
        wb_dat_i   = 32'h0;
        wb_sel_i   = 4'h0;
        mismatches = 0;
        num_checks = 0;
        cycles     = 0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        test_reset();
        test_bclr();
        test_branch();
        give_verdict();
    end
endmodule
